// file: cbps_bridge.sv
// processor-bus slave path: window decode, translation, posted-write fifo
`timescale 1ns/1ps
module cbps_bridge #(
    parameter logic [15:0] OWN_BASE = cbps_pkg::OWN_BASE_DEF,
    parameter int DEPTH = cbps_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cpu_req,
    input wire logic [cbps_pkg::TT_W-1:0] cpu_tt,
    input wire logic [cbps_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_burst,
    input wire logic [cbps_pkg::BE_W-1:0] cpu_be,
    input wire logic [cbps_pkg::DATA_W-1:0] cpu_wdata,
    output logic cpu_ack,
    output logic [cbps_pkg::DATA_W-1:0] cpu_rdata,
    input wire logic [cbps_pkg::RADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic pci_valid,
    input wire logic pci_ready,
    output logic pci_write,
    output logic pci_io,
    output logic [1:0] pci_xfer,
    output logic [cbps_pkg::ADDR_W-1:0] pci_addr,
    output logic [cbps_pkg::BE_W-1:0] pci_be,
    output logic [cbps_pkg::DATA_W-1:0] pci_wdata,
    input wire logic pci_rvalid,
    input wire logic [cbps_pkg::DATA_W-1:0] pci_rdata
);
    import cbps_pkg::*;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);
    localparam int LO_W = ADDR_W - HI_W;

    ////////////////////////////////////////////////////////////////////////////
    // registers, processor side only
    logic [HI_W-1:0] win_lo [NWIN];
    logic [HI_W-1:0] win_hi [NWIN];
    logic [HI_W-1:0] win_off [NWIN];
    logic [CTL_W-1:0] win_ctl [NWIN];
    logic little;
    logic [CW-1:0] count;
    cbps_state_t state;
    logic [31:0] status;
    assign status = {{(32 - CW - 1){1'b0}}, count, state != S_IDLE};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NWIN; i++) begin
                win_lo[i] <= '0;
                win_hi[i] <= '0;
                win_off[i] <= '0;
                win_ctl[i] <= CTL_RESET;
            end
            little <= 1'b0;
            reg_rdata <= '0;
        end else begin
            for (int i = 0; i < NWIN; i++) begin
                if (reg_wr && reg_addr == REG_WIN_RANGE + 8'(i) * REG_WIN_STRIDE) begin
                    win_lo[i] <= reg_wdata[HI_W-1:0];
                    win_hi[i] <= reg_wdata[31:HI_W];
                end
                if (reg_wr && reg_addr == REG_WIN_CTRL + 8'(i) * REG_WIN_STRIDE) begin
                    win_ctl[i] <= reg_wdata[CTL_W-1:0];
                    win_off[i] <= reg_wdata[31:OFF_LSB];
                end
            end
            if (reg_wr && reg_addr == REG_GCTL)
                little <= reg_wdata[GCTL_LITTLE];
            reg_rdata <= '0;
            if (reg_rd) begin
                for (int i = 0; i < NWIN; i++) begin
                    if (reg_addr == REG_WIN_RANGE + 8'(i) * REG_WIN_STRIDE)
                        reg_rdata <= {win_hi[i], win_lo[i]};
                    if (reg_addr == REG_WIN_CTRL + 8'(i) * REG_WIN_STRIDE)
                        reg_rdata <= {win_off[i], {(OFF_LSB - CTL_W){1'b0}}, win_ctl[i]};
                end
                if (reg_addr == REG_GCTL)
                    reg_rdata <= {31'h0000_0000, little};
                if (reg_addr == REG_STAT)
                    reg_rdata <= status;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode
    function automatic logic [DATA_W-1:0] swap(input logic [DATA_W-1:0] d, input logic en);
        logic [DATA_W-1:0] r;
        r = d;
        if (en)
            for (int b = 0; b < BE_W; b++)
                r[b*8 +: 8] = d[(BE_W-1-b)*8 +: 8];
        return r;
    endfunction

    cbps_cls_t cls;
    logic [HI_W-1:0] hi;
    logic own, any_hit, sel_ok;
    logic [$clog2(NWIN)-1:0] sel;
    assign hi = cpu_addr[ADDR_W-1:LO_W];
    assign own = hi == OWN_BASE;
    always_comb begin
        if (TT_ADDR_ONLY[cpu_tt]) cls = C_ADDR;
        else if (TT_READ[cpu_tt]) cls = C_READ;
        else if (TT_WRITE[cpu_tt]) cls = C_WRITE;
        else cls = C_NONE;
        any_hit = 1'b0;
        sel = '0;
        for (int i = NWIN - 1; i >= 0; i--) begin
            if (hi >= win_lo[i] && hi <= win_hi[i]) begin
                any_hit = 1'b1;
                sel = ($clog2(NWIN))'(i);
            end
        end
        sel_ok = any_hit && (cls == C_READ ? win_ctl[sel][CTL_RD_EN]
                                           : win_ctl[sel][CTL_WR_EN]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // posted-write fifo and request sequencer
    logic [ADDR_W-1:0] f_addr [DEPTH];
    logic [DATA_W-1:0] f_data [DEPTH];
    logic [BE_W-1:0] f_be [DEPTH];
    logic [CTL_W-1:0] f_ctl [DEPTH];
    logic [PW-1:0] wp, rp;
    logic [ADDR_W-1:0] l_addr, next_l_addr;
    logic [BE_W-1:0] l_be, next_l_be;
    logic [CTL_W-1:0] l_ctl, next_l_ctl;
    logic l_read, next_l_read, l_own, next_l_own, l_post, next_l_post;
    logic [1:0] beat, next_beat;
    cbps_state_t next_state;
    logic [DATA_W-1:0] next_cpu_rdata;
    logic push, pop, room;
    logic [ADDR_W-1:0] push_addr, xaddr;
    // a burst needs all its beats free before the acknowledge
    assign room = cpu_burst ? (32'(count) + BURST_BEATS <= DEPTH)
                            : (32'(count) < DEPTH);
    assign xaddr = {hi + win_off[sel], cpu_addr[LO_W-1:0]};
    assign pop = pci_valid && pci_ready && pci_write;
    assign push_addr = state == S_BEAT ? l_addr + {{(ADDR_W-5){1'b0}}, beat, 3'b000} : xaddr;
    always_comb begin
        next_state = state;
        next_l_addr = l_addr;
        next_l_be = l_be;
        next_l_ctl = l_ctl;
        next_l_read = l_read;
        next_l_own = l_own;
        next_l_post = l_post;
        next_beat = beat;
        next_cpu_rdata = cpu_rdata;
        push = 1'b0;
        cpu_ack = 1'b0;
        case (state)
            S_IDLE: begin
                if (cpu_req) begin
                    next_l_addr = xaddr;
                    next_l_be = cpu_be;
                    next_l_ctl = win_ctl[sel];
                    next_l_read = cls == C_READ;
                    next_l_own = own;
                    next_l_post = win_ctl[sel][CTL_POST_EN];
                    next_beat = 2'd1;
                    if (cls == C_ADDR)
                        cpu_ack = own || any_hit;
                    else if ((cls == C_READ || cls == C_WRITE) && own)
                        next_state = S_WAIT;
                    else if (cls == C_READ && sel_ok)
                        next_state = S_WAIT;
                    else if (cls == C_WRITE && sel_ok && room) begin
                        push = 1'b1;
                        cpu_ack = win_ctl[sel][CTL_POST_EN];
                        if (cpu_burst)
                            next_state = S_BEAT;
                        else if (!win_ctl[sel][CTL_POST_EN])
                            next_state = S_WAIT;
                    end
                end
            end
            S_BEAT: begin
                push = 1'b1;
                next_beat = beat + 2'd1;
                if (beat == 2'(BURST_BEATS - 1))
                    next_state = l_post ? S_IDLE : S_WAIT;
            end
            S_WAIT: begin
                if (count == '0) begin
                    if (l_own && l_read) begin
                        next_cpu_rdata = {32'h0000_0000, status};
                        next_state = S_RDONE;
                    end else if (l_read)
                        next_state = S_RISS;
                    else begin
                        cpu_ack = 1'b1;
                        next_state = S_IDLE;
                    end
                end
            end
            S_RISS: if (pci_ready) next_state = S_RWAIT;
            S_RWAIT: begin
                if (pci_rvalid) begin
                    next_cpu_rdata = swap(pci_rdata, little);
                    next_state = S_RDONE;
                end
            end
            S_RDONE: begin
                cpu_ack = 1'b1;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            l_addr <= '0;
            l_be <= '0;
            l_ctl <= CTL_RESET;
            l_read <= 1'b0;
            l_own <= 1'b0;
            l_post <= 1'b0;
            beat <= '0;
            cpu_rdata <= '0;
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            state <= next_state;
            l_addr <= next_l_addr;
            l_be <= next_l_be;
            l_ctl <= next_l_ctl;
            l_read <= next_l_read;
            l_own <= next_l_own;
            l_post <= next_l_post;
            beat <= next_beat;
            cpu_rdata <= next_cpu_rdata;
            if (push) begin
                f_addr[wp] <= push_addr;
                f_data[wp] <= swap(cpu_wdata, little);
                f_be[wp] <= state == S_BEAT ? l_be : cpu_be;
                f_ctl[wp] <= state == S_BEAT ? l_ctl : win_ctl[sel];
                wp <= wp == PW'(DEPTH - 1) ? '0 : wp + 1'b1;
            end
            if (pop)
                rp <= rp == PW'(DEPTH - 1) ? '0 : rp + 1'b1;
            count <= count + CW'(push) - CW'(pop);
        end
    end
    // fifo head goes first; a read is only offered once the fifo is empty
    always_comb begin
        pci_valid = count != '0 || state == S_RISS;
        pci_write = count != '0;
        pci_addr = pci_write ? f_addr[rp] : l_addr;
        pci_be = pci_write ? f_be[rp] : l_be;
        pci_wdata = f_data[rp];
        pci_io = pci_write ? f_ctl[rp][CTL_IO] : l_ctl[CTL_IO];
        pci_xfer = pci_write ? f_ctl[rp][CTL_XFER_LSB +: 2] : l_ctl[CTL_XFER_LSB +: 2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_burst_go;
        state == S_IDLE && cpu_req && cls == C_WRITE && sel_ok && room && cpu_burst;
    endsequence
    sequence s_beats;
        state == S_BEAT [*3] ##1 state != S_BEAT;
    endsequence
    property p_burst;
        @(posedge core_clk) disable iff (!rst_n) s_burst_go |=> s_beats;
    endproperty
    a_burst: assert property (p_burst) else $error("burst beat count wrong");
    property p_cap;
        @(posedge core_clk) disable iff (!rst_n) 32'(count) <= DEPTH;
    endproperty
    a_cap: assert property (p_cap) else $error("fifo overfilled");
    property p_read_drain;
        @(posedge core_clk) disable iff (!rst_n)
            state == S_RISS |-> count == '0 && pci_valid && !pci_write;
    endproperty
    a_read_drain: assert property (p_read_drain) else $error("read passed posted data");
    property p_none;
        @(posedge core_clk) disable iff (!rst_n)
            state == S_IDLE && cls == C_NONE |-> !cpu_ack ##1 state == S_IDLE;
    endproperty
    a_none: assert property (p_none) else $error("no-response code answered");
    property p_unmapped;
        @(posedge core_clk) disable iff (!rst_n)
            state == S_IDLE && cpu_req && cls == C_READ && !own && !sel_ok
            |-> !cpu_ack ##1 state == S_IDLE;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access claimed");
    property p_addr_only;
        @(posedge core_clk) disable iff (!rst_n)
            state == S_IDLE && cpu_req && cls == C_ADDR |-> cpu_ack == (own || any_hit);
    endproperty
    a_addr_only: assert property (p_addr_only) else $error("address-only answer wrong");
    property p_post;
        @(posedge core_clk) disable iff (!rst_n)
            state == S_IDLE && cpu_ack && cls == C_WRITE && !pop |=> count == $past(count) + 1'b1;
    endproperty
    a_post: assert property (p_post) else $error("posted write not queued");
    property p_own;
        @(posedge core_clk) disable iff (!rst_n)
            cpu_ack && l_own && state != S_IDLE |-> count == '0;
    endproperty
    a_own: assert property (p_own) else $error("own access before drain");
    property p_xlate;
        @(posedge core_clk) disable iff (!rst_n)
            state == S_IDLE && cpu_req && cls == C_READ && sel_ok && !own
            |=> l_addr[LO_W-1:0] == $past(cpu_addr[LO_W-1:0]);
    endproperty
    a_xlate: assert property (p_xlate) else $error("low address bits altered");
endmodule

// file: cbps_bridge_tb.sv
// self-checking bench for the processor-bus to pci slave path
`timescale 1ns/1ps
module cbps_bridge_tb;
    import cbps_pkg::*;
    typedef struct packed {
        logic wr; logic io; logic [1:0] xf;
        logic [31:0] a; logic [7:0] be; logic [63:0] d;
    } cbps_exp_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cpu_req = 1'b0, cpu_burst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
    logic little = 1'b0, got, cpu_ack, pci_valid, pci_ready, pci_write, pci_io, pci_rvalid;
    logic [1:0] pci_xfer;
    logic [4:0] cpu_tt = '0;
    logic [7:0] cpu_be = '0, reg_addr = '0, be = 8'hFF, pci_be;
    logic [31:0] cpu_addr = '0, reg_wdata = '0, reg_rdata, pci_addr, a;
    logic [63:0] cpu_wdata = '0, cpu_rdata, pci_wdata, pci_rdata, d, rd;
    cbps_exp_t q[$];
    cbps_exp_t e;
    logic [31:0] rq[$];
    logic rd_d = 1'b0;
    int error_cnt = 0, cmp_count = 0;
    logic [31:0] cfg[6] = '{32'h10FF_1000, 32'h2000_0017, 32'h2000_2000, 32'h0001_002B,
        32'h3000_3000, 32'h0000_0001};
    cbps_bridge u_dut (.core_clk, .rst_n, .cpu_req, .cpu_tt, .cpu_addr, .cpu_burst, .cpu_be,
        .cpu_wdata, .cpu_ack, .cpu_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pci_valid, .pci_ready, .pci_write, .pci_io, .pci_xfer, .pci_addr, .pci_be, .pci_wdata,
        .pci_rvalid, .pci_rdata);
    cbps_pci_model u_pci (.core_clk, .rst_n, .stall, .pci_valid, .pci_write, .pci_addr,
        .pci_ready, .pci_rvalid, .pci_rdata);
    always #2.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] cls(input logic [4:0] c);
        casez (c)
            5'b00?00, 5'b01?00, 5'b10000, 5'b11000, 5'b0??01: return 2'd1;
            5'b01?10, 5'b11?10, 5'b01011: return 2'd2;
            5'b00?10, 5'b10010: return 2'd3;
            default: return 2'd0;
        endcase
    endfunction
    function automatic logic [31:0] xl(input logic [31:0] x, input logic [15:0] off);
        return {x[31:16] + off, x[15:0]};
    endfunction
    function automatic logic [63:0] sw(input logic [63:0] v);
        logic [63:0] r;
        for (int i = 0; i < 8; i++) r[8*i+:8] = v[8*(7-i)+:8];
        return little ? r : v;
    endfunction
    task automatic chk(input logic [63:0] s, input logic [63:0] x);
        cmp_count++;
        if (s !== x) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic stop_test;
        $display("TB: errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic rw(input logic [7:0] ad, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // the expected word is queued; the register watcher checks it a cycle later
    task automatic rr(input logic [7:0] ad, input logic [31:0] x);
        rq.push_back(x);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    // a refused request is dropped after lim cycles, as a real master must
    task automatic op(input logic [4:0] tt, input logic [31:0] ad, input logic b,
        input logic [63:0] v, input int lim, output logic g, output logic [63:0] r);
        @(posedge core_clk);
        cpu_req <= 1'b1;
        cpu_tt <= tt;
        cpu_addr <= ad;
        cpu_burst <= b;
        cpu_be <= be;
        cpu_wdata <= v;
        g = 1'b0;
        r = '0;
        for (int n = 0; n < lim && !g; n++) begin
            @(posedge core_clk);
            g = (cpu_ack === 1'b1);
            r = cpu_rdata;
        end
        cpu_req <= 1'b0;
        if (g && b) for (int k = 1; k < 4; k++) begin
            cpu_wdata <= v + 64'(k);
            @(posedge core_clk);
        end
    endtask
    task automatic pw(input logic [31:0] wa, input logic b, input logic [63:0] v, input int lim);
        for (int k = 0; k < (b ? 4 : 1); k++) q.push_back(cbps_exp_t'({1'b1, 1'b0, 2'h1,
            xl(wa + 32'(8 * k), 16'h2000), be, sw(v + 64'(k))}));
        op(5'b00010, wa, b, v, lim, got, rd);
    endtask
    task automatic rd0(input logic [4:0] tt, input logic [31:0] ra);
        logic [31:0] pa;
        pa = xl(ra, 16'h2000);
        q.push_back(cbps_exp_t'({1'b0, 1'b0, 2'h1, pa, be, 64'h0}));
        op(tt, ra, 1'b0, '0, 60, got, rd);
        chk(got, 1'b1);
        chk(rd, sw({pa, ~pa}));
    endtask
    task automatic drain;
        for (int n = 0; n < 400 && q.size() != 0; n++) @(posedge core_clk);
        @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (rst_n && pci_valid === 1'b1 && pci_ready === 1'b1) begin
            if (q.size() == 0) begin
                chk(64'(q.size()), 64'h0000_0000_0000_0001);
            end else begin
                e = q.pop_front();
                chk(pci_addr, e.a);
                chk({pci_write, pci_io, pci_xfer}, {e.wr, e.io, e.xf});
                if (e.wr) chk({pci_be, pci_wdata[55:0]}, {e.be, e.d[55:0]});
                if (e.wr) chk(pci_wdata, e.d);
            end
        end
    end
    // read data stand only in the cycle after the strobe
    always @(posedge core_clk) begin
        rd_d <= reg_rd;
        if (rd_d) chk(reg_rdata, rq.pop_front());
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        stop_test;
    end
    initial begin
        void'($urandom(32'hdd2f));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rr(8'(4 * i), '0);
        rw(8'h30, 32'hFFFF_FFFF);
        rr(8'h30, '0);
        for (int i = 0; i < 6; i++) rw(8'(4 * i), cfg[i]);
        for (int i = 0; i < 6; i++) rr(8'(4 * i), cfg[i]);
        repeat (6) begin
            be = 8'($urandom);
            d = {$urandom, $urandom};
            a = {16'($urandom_range(16'h10FF, 16'h1000)), 11'($urandom), 5'h00};
            pw(a, 1'($urandom), d, 30);
            chk(got, 1'b1);
        end
        pw(32'h10FF_FFE0, 1'b0, d, 30);
        chk(got, 1'b1);
        op(5'b01010, 32'h1100_0000, 1'b0, '0, 8, got, rd);
        chk(got, 1'b0);
        op(5'b00010, 32'h0FFF_FFF8, 1'b0, d, 8, got, rd);
        chk(got, 1'b0);
        op(5'b00010, 32'h3000_0010, 1'b0, d, 8, got, rd);
        chk(got, 1'b0);
        for (int c = 0; c < 32; c++) begin
            a = {16'h1000 + 16'($urandom_range(255)), 16'($urandom) & 16'hFFF8};
            d = {$urandom, $urandom};
            case (cls(5'(c)))
                2'd1: begin
                    drain;
                    op(5'(c), a, 1'b0, '0, 2, got, rd);
                    chk(got, 1'b1);
                    op(5'(c), 32'h5000_0000, 1'b0, '0, 6, got, rd);
                    chk(got, 1'b0);
                end
                2'd2: rd0(5'(c), a);
                2'd3: begin
                    pw(a, 1'b0, d, 30);
                    chk(got, 1'b1);
                end
                default: begin
                    op(5'(c), a, 1'b0, d, 6, got, rd);
                    chk(got, 1'b0);
                end
            endcase
        end
        // hold pci off so the fifo fills with a burst plus singles
        drain;
        stall <= 1'b1;
        pw(32'h1000_0100, 1'b1, d, 1);
        chk(got, 1'b1);
        for (int i = 0; i < 4; i++) begin
            pw(32'h1000_0200 + 32'(8 * i), 1'b0, d + 64'(i), 1);
            chk(got, 1'b1);
        end
        op(5'b00010, 32'h1000_0300, 1'b0, d, 12, got, rd);
        chk(got, 1'b0);
        op(5'b00010, {OWN_BASE_DEF, 16'h0010}, 1'b0, d, 8, got, rd);
        chk(got, 1'b0);
        stall <= 1'b0;
        op(5'b00010, {OWN_BASE_DEF, 16'h0010}, 1'b0, d, 80, got, rd);
        chk(got, 1'b1);
        pw(32'h1000_0400, 1'b0, d, 40);
        chk(got, 1'b1);
        q.push_back(cbps_exp_t'({1'b1, 1'b1, 2'h2, xl(32'h2000_1230, 16'h0001), be, sw(d)}));
        op(5'b00110, 32'h2000_1230, 1'b0, d, 80, got, rd);
        chk(got, 1'b1);
        rd0(5'b01010, 32'h1000_0500);
        drain;
        little = 1'b1;
        be = 8'hFF;
        rw(REG_GCTL, 32'h0000_0001);
        pw(32'h1000_0600, 1'b0, d, 40);
        chk(got, 1'b1);
        rd0(5'b01010, 32'h1000_0608);
        drain;
        little = 1'b0;
        rw(REG_GCTL, '0);
        chk(64'(q.size()), '0);
        stop_test;
    end
endmodule

// file: cbps_pci_model.sv
// pci-side target model that answers the bridge's requests
`timescale 1ns/1ps
module cbps_pci_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic pci_valid,
    input wire logic pci_write,
    input wire logic [31:0] pci_addr,
    output logic pci_ready,
    output logic pci_rvalid,
    output logic [63:0] pci_rdata
);
    logic phase;
    logic [2:0] cnt;
    logic [31:0] ra;
    logic [31:0] pat;
    // idle data lines move every cycle so a stale sample never passes
    assign pci_rdata = pci_rvalid ? {ra, ~ra} : {pat, ~pat};
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 1'b0;
            cnt <= 3'h0;
            ra <= '0;
            pat <= '0;
            pci_ready <= 1'b0;
            pci_rvalid <= 1'b0;
        end else begin
            phase <= ~phase;
            pat <= pat + 32'h0000_1235;
            // ready only on alternate ticks, with random extra stalls
            pci_ready <= !stall && !phase && ($urandom_range(3) != 0);
            pci_rvalid <= (cnt == 3'h1);
            if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
            end
            if (pci_valid && pci_ready && !pci_write) begin
                ra <= pci_addr;
                cnt <= 3'($urandom_range(4, 1));
            end
        end
    end
endmodule

// file: cbps_pkg.sv
// package: constants for the processor-bus to pci slave path
package cbps_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam int BE_W = 8;
    localparam int TT_W = 5;
    localparam int HI_W = 16;
    localparam int NWIN = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int BURST_BEATS = 4;
    localparam int RADDR_W = 8;
    // transfer code classes, one bit per 5-bit code
    localparam logic [31:0] TT_ADDR_ONLY = 32'h0101_3333;
    localparam logic [31:0] TT_READ = 32'h4400_4C00;
    localparam logic [31:0] TT_WRITE = 32'h0004_0044;
    // register byte addresses
    localparam logic [7:0] REG_WIN_RANGE = 8'h00;
    localparam logic [7:0] REG_WIN_CTRL = 8'h04;
    localparam logic [7:0] REG_WIN_STRIDE = 8'h08;
    localparam logic [7:0] REG_GCTL = 8'h20;
    localparam logic [7:0] REG_STAT = 8'h24;
    // window control fields
    localparam int CTL_RD_EN = 0;
    localparam int CTL_WR_EN = 1;
    localparam int CTL_POST_EN = 2;
    localparam int CTL_IO = 3;
    localparam int CTL_XFER_LSB = 4;
    localparam int CTL_W = 6;
    localparam int OFF_LSB = 16;
    localparam int GCTL_LITTLE = 0;
    localparam logic [15:0] OWN_BASE_DEF = 16'hFEFF;
    localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;
    typedef enum logic [1:0] {C_NONE, C_ADDR, C_READ, C_WRITE} cbps_cls_t;
    typedef enum {S_IDLE, S_BEAT, S_WAIT, S_RISS, S_RWAIT, S_RDONE} cbps_state_t;
endpackage
